/* pkg/twoq_consts.svh */
`ifndef TWOQ_CONSTS_SVH
`define TWOQ_CONSTS_SVH
`define TWOQ_DATA_W 26
`define TWOQ_TAG_W 8
`define TWOQ_TIME_W 5
`define TWOQ_WORD_W 39
`define TWOQ_XFER_W 40
`define TWOQ_CHANNELS 4
`define TWOQ_TAG_ORIGIN_BIT 7
`define TWOQ_TM_VALID_BIT 0
`define TWOQ_TM_MODE_LSB 1
`define TWOQ_TM_ADDR_BIT 4
`define TWOQ_READ_PERIOD_US 4170
`define TWOQ_CLK_MHZ 10
`endif

/* pkg/twoq_pkg.sv */
package twoq_pkg;
    typedef enum logic [1:0] {TWOQ_SRC_PASS, TWOQ_SRC_PIO, TWOQ_SRC_ERR} twoq_src_t;
endpackage

/* core/twoq_top.sv */
`timescale 1ns/100ps
`include "twoq_consts.svh"
module twoq_top
    import twoq_pkg::*;
#(
    parameter int CHANNELS = `TWOQ_CHANNELS
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic word_req,
    input wire twoq_src_t word_src,
    input wire logic [`TWOQ_DATA_W-1:0] word_data,
    input wire logic [6:0] word_source_tag,
    input wire logic [`TWOQ_TIME_W-1:0] real_time,
    input wire logic error_flag,
    input wire logic [`TWOQ_DATA_W-1:0] error_snapshot,
    input wire logic cpu_load,
    input wire logic [`TWOQ_DATA_W-1:0] cpu_data,
    input wire logic [8:0] cpu_addr,
    input wire logic [2:0] mode_bits,
    input wire logic mux_sync_pin,
    output logic [`TWOQ_DATA_W-1:0] telemetry_data_buffer,
    output logic [`TWOQ_TIME_W-1:0] telemetry_time_mode_validity,
    output logic [`TWOQ_TAG_W-1:0] telemetry_tag,
    output logic telemetry_parity,
    output logic word_req_ready
);
    localparam logic [6:0] ERR_TAG = 7'h7F;
    ////////////////////////////////////////////////////////////////////////////
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic [`TWOQ_WORD_W-1:0] chan_word [CHANNELS];
    logic [CHANNELS-1:0] chan_full;
    logic [$clog2(CHANNELS)-1:0] present_idx;
    logic present_valid;
    logic [`TWOQ_WORD_W-1:0] next_word;
    logic [CHANNELS-1:0] take_free;
    logic [CHANNELS-1:0] take_full;
    logic [$clog2(CHANNELS)-1:0] full_idx;
    logic any_full;
    logic [CHANNELS-1:0] full_after;
    logic cpu_held;
    wire sync_edge = sync_s2 & ~sync_s3;
    // An error snapshot needs no instruction and overrides a same-cycle request.
    wire build = word_req | error_flag;
    // Tag bit 7 (msb) is zero for every adapter word.
    wire [`TWOQ_TAG_W-1:0] build_tag = error_flag ? {1'b0, ERR_TAG} : {1'b0, word_source_tag};
    wire [`TWOQ_DATA_W-1:0] build_data = error_flag ? error_snapshot : word_data;
    ////////////////////////////////////////////////////////////////////////////
    // Word layout {data, tag, time} is the delay-line channel format.
    assign next_word = {build_data, build_tag, real_time};
    // Lowest free channel takes a new word; lowest full one is presented.
    always_comb
    begin
        take_free = '0;
        take_full = '0;
        full_idx = '0;
        any_full = 1'b0;
        for (int i = CHANNELS - 1; i >= 0; i--)
        begin
            if (!chan_full[i])
            begin
                take_free = '0;
                take_free[i] = 1'b1;
            end
        end
        for (int i = CHANNELS - 1; i >= 0; i--)
        begin
            if (full_after[i])
            begin
                full_idx = i[$clog2(CHANNELS)-1:0];
                any_full = 1'b1;
            end
        end
    end
    // A synced word leaves the queue only once the multiplexer has read it.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_chan
            // A computer word covered the presented one, so the multiplexer never read it.
            wire drop = sync_edge & present_valid & ~cpu_held & (present_idx == g);
            wire load = build & take_free[g];
            assign full_after[g] = (chan_full[g] & ~drop);
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                    chan_full[g] <= 1'b0;
                else
                    chan_full[g] <= full_after[g] | load;
            end
            always_ff @(posedge clk)
            begin
                if (load)
                    chan_word[g] <= next_word;
            end
        end
    endgenerate
    assign word_req_ready = ~&chan_full;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
        end
        else
        begin
            sync_s1 <= mux_sync_pin;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end
    wire [`TWOQ_TIME_W-1:0] cpu_tmv = {cpu_addr[8], mode_bits, 1'b1};
    wire [`TWOQ_TAG_W-1:0] cpu_tag = {1'b1, cpu_addr[6:0]};
    wire [`TWOQ_WORD_W-1:0] shown = any_full ? chan_word[full_idx] : '0;
    wire [`TWOQ_WORD_W-1:0] loaded = cpu_load ? {cpu_data, cpu_tag, cpu_tmv} : shown;
    wire [`TWOQ_WORD_W-1:0] cpu_done = {telemetry_data_buffer, telemetry_tag,
        telemetry_time_mode_validity[`TWOQ_TIME_W-1:1], 1'b0};
    logic cpu_loading;
    // The validity bit is 1 while loading and drops when the load ends.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            {telemetry_data_buffer, telemetry_tag, telemetry_time_mode_validity} <= '0;
            telemetry_parity <= 1'b1;
            present_idx <= '0;
            present_valid <= 1'b0;
            cpu_held <= 1'b0;
            cpu_loading <= 1'b0;
        end
        else
        begin
            cpu_loading <= cpu_load;
            if (cpu_load)
            begin
                {telemetry_data_buffer, telemetry_tag, telemetry_time_mode_validity} <= loaded;
                telemetry_parity <= ~^loaded;
                cpu_held <= 1'b1;
            end
            else if (cpu_loading)
            begin
                telemetry_time_mode_validity[`TWOQ_TM_VALID_BIT] <= 1'b0;
                telemetry_parity <= ~^cpu_done;
            end
            else if (sync_edge || (!cpu_held && !present_valid && any_full))
            begin
                {telemetry_data_buffer, telemetry_tag, telemetry_time_mode_validity} <= shown;
                telemetry_parity <= ~^shown;
                present_idx <= full_idx;
                present_valid <= any_full;
                cpu_held <= 1'b0;
            end
        end
    end
    // are kept by the multiplexer and flight program.
    ////////////////////////////////////////////////////////////////////////////
    a_parity_odd: assert property (@(posedge clk) disable iff (!rst_b)
        ^{telemetry_data_buffer, telemetry_tag, telemetry_time_mode_validity, telemetry_parity})
        else $error("telemetry transfer parity not odd");
    a_cpu_tag_mark: assert property (@(posedge clk) disable iff (!rst_b)
        cpu_load |=> telemetry_tag[`TWOQ_TAG_ORIGIN_BIT] && telemetry_time_mode_validity[0])
        else $error("computer word not marked");
    a_valid_drops: assert property (@(posedge clk) disable iff (!rst_b)
        cpu_load ##1 !cpu_load |=> !telemetry_time_mode_validity[0])
        else $error("validity bit stuck");
    a_empty_zero: assert property (@(posedge clk) disable iff (!rst_b)
        sync_edge && !cpu_load && !cpu_loading && !any_full |=> telemetry_tag == '0)
        else $error("empty queue not zero");
    a_adapter_tag0: assert property (@(posedge clk) disable iff (!rst_b)
        sync_edge && !cpu_load && !cpu_loading && any_full |=> !telemetry_tag[`TWOQ_TAG_ORIGIN_BIT])
        else $error("adapter word tag bit set");
    a_word_kept: assert property (@(posedge clk) disable iff (!rst_b)
        cpu_load && present_valid |=> chan_full[$past(present_idx)])
        else $error("overwritten word lost");
    a_err_queued: assert property (@(posedge clk) disable iff (!rst_b)
        error_flag && !(&chan_full) && !sync_edge |=> $countones(chan_full) == $countones($past(chan_full)) + 1)
        else $error("error word not queued");
    a_sync_load: assert property (@(posedge clk) disable iff (!rst_b)
        sync_edge && !cpu_load && !cpu_loading |=> present_valid == $past(any_full))
        else $error("sync did not gate next word");
    c_cpu_word: cover property (@(posedge clk) disable iff (!rst_b) cpu_load ##1 !cpu_load);
    c_queue_full: cover property (@(posedge clk) disable iff (!rst_b) &chan_full);
    c_sync_full: cover property (@(posedge clk) disable iff (!rst_b) sync_edge && any_full);
endmodule

/* tb/twoq_mux_model.sv */
`timescale 1ns/100ps
`include "twoq_consts.svh"
// Stands in for the multiplexer: samples the registers on request and raises sync on the same edge.
module twoq_mux_model (
    input wire logic clk,
    input wire logic read_now,
    input wire logic [`TWOQ_DATA_W-1:0] data,
    input wire logic [`TWOQ_TAG_W-1:0] tag,
    input wire logic [`TWOQ_TIME_W-1:0] tmv,
    input wire logic parity,
    output logic mux_sync_pin,
    output logic [`TWOQ_XFER_W-1:0] sample
);
    int hold = 0;
    initial mux_sync_pin = 1'b0;
    initial sample = '0;
    always @(posedge clk)
    begin
        if (read_now)
        begin
            sample <= {data, tag, tmv, parity};
            hold <= 3;
        end
        else if (hold > 0)
            hold <= hold - 1;
        // The pulse lasts three cycles so the two-flop synchroniser cannot miss it.
        mux_sync_pin <= read_now || hold > 1;
    end
endmodule

/* tb/tb_telemetry_word_output_queue.sv */
`timescale 1ns/100ps
`include "twoq_consts.svh"
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s expected %h seen %h", w, e, g); end end
module tb_telemetry_word_output_queue
    import twoq_pkg::*;
;
    typedef struct packed {logic [25:0] d; logic [6:0] t; logic [4:0] tm;} twoq_row_t;
    twoq_row_t rows [3] = '{'{26'h3FF_FFFF, 7'h01, 5'h1F}, '{26'h000_0001, 7'h7E, 5'h00},
        '{26'h155_5555, 7'h2A, 5'h0A}};
    logic clk = 0, rst_b = 0, word_req = 0, error_flag = 0, cpu_load = 0, read_now = 0;
    logic [25:0] word_data = '0, error_snapshot = '0, cpu_data = '0, buf_q;
    logic [6:0] word_source_tag = '0;
    logic [4:0] real_time = '0, tmv;
    logic [8:0] cpu_addr = '0;
    logic [2:0] mode_bits = '0;
    logic [7:0] tag, seen;
    logic par, sync_pin, ready;
    logic [39:0] smp;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    always #50 clk = ~clk;
    twoq_top u_dut (.clk(clk), .rst_b(rst_b), .word_req(word_req), .word_src(TWOQ_SRC_PIO),
        .word_data(word_data), .word_source_tag(word_source_tag), .real_time(real_time),
        .error_flag(error_flag), .error_snapshot(error_snapshot), .cpu_load(cpu_load),
        .cpu_data(cpu_data), .cpu_addr(cpu_addr), .mode_bits(mode_bits), .mux_sync_pin(sync_pin),
        .telemetry_data_buffer(buf_q), .telemetry_time_mode_validity(tmv), .telemetry_tag(tag),
        .telemetry_parity(par), .word_req_ready(ready));
    twoq_mux_model u_mux (.clk(clk), .read_now(read_now), .data(buf_q), .tag(tag), .tmv(tmv),
        .parity(par), .mux_sync_pin(sync_pin), .sample(smp));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic look(input logic [25:0] d, input logic [7:0] t, input logic [4:0] tm);
        `CHK("registers", {d, t, tm}, {buf_q, tag, tmv})
        `CHK("parity", ~^{d, t, tm}, par)
    endtask
    task automatic push(input twoq_row_t r);
        {word_data, word_source_tag, real_time} = r;
        word_req = 1;
        tick(1);
        word_req = 0;
        tick(2);
    endtask
    // Reads are spaced a few cycles apart instead of the real 4.17 ms period.
    task automatic sync();
        read_now = 1;
        tick(1);
        read_now = 0;
        tick(8);
        `CHK("odd read", 1'b1, ^smp)
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(6);
        rst_b = 1;
        look('0, '0, '0);
        `CHK("ready", 1'b1, ready)
        for (int i = 0; i < 3; i++)
        begin
            push(rows[i]);
            look(rows[i].d, {1'b0, rows[i].t}, rows[i].tm);
            sync();
            look('0, '0, '0);
            $display("row %0d done", i);
        end
        word_req = 1;
        for (int k = 1; k < 5; k++)
        begin
            word_source_tag = 7'(k);
            tick(1);
        end
        `CHK("full", 1'b0, ready)
        word_source_tag = 7'h05;
        tick(1);
        word_req = 0;
        seen = '0;
        for (int k = 0; k < 4; k++)
        begin
            `CHK("fresh tag", 1'b1, tag inside {[1:4]} && !seen[tag[2:0]])
            seen[tag[2:0]] = 1;
            sync();
        end
        look('0, '0, '0);
        $display("queue fill done");
        error_snapshot = 26'h2AB_CDEF;
        real_time = 5'h15;
        error_flag = 1;
        tick(1);
        error_flag = 0;
        tick(2);
        look(26'h2AB_CDEF, 8'h7F, 5'h15);
        sync();
        $display("error word done");
        push(rows[2]);
        {cpu_data, cpu_addr, mode_bits} = {26'h0C3_A5F0, 9'h125, 3'h5};
        cpu_load = 1;
        tick(1);
        `CHK("valid while loading", 1'b1, tmv[0])
        cpu_load = 0;
        tick(1);
        look(26'h0C3_A5F0, 8'hA5, 5'h1A);
        sync();
        look(rows[2].d, {1'b0, rows[2].t}, rows[2].tm);
        sync();
        look('0, '0, '0);
        $display("computer word done");
        tally_and_finish();
    end
endmodule
